// >>> hw/inval_queue_defs.svh
`ifndef INVAL_QUEUE_DEFS_SVH
`define INVAL_QUEUE_DEFS_SVH
// Contract
// - queue base 4KB aligned, bits 11:3 zero
// - base bits above host width may be dropped
// - base reads back last written value
// - size X means 2^(X+8) entries
// - no queue support: registers read zero
// - notify wait done sets sticky flag, W1C
// - event mask resets to one
// - unmasked condition sends message
// - never send message while masked
// - new condition sets pending bit
// - flag already set: no new condition
// - pending stays while message held
// - pending clears once message sent
// - clearing flag drops held message, pending
// - fetch offset zero while queue disabled
// - payload is event data low 16 bits
// - target is event address bits 31:2
`define OFF_QHEAD     12'h080
`define OFF_QTAIL     12'h088
`define OFF_QBASE_LO  12'h090
`define OFF_QBASE_HI  12'h094
`define OFF_DONE      12'h09c
`define OFF_EV_CTL    12'h0a0
`define OFF_EV_DATA   12'h0a4
`define OFF_EV_ADDR   12'h0a8
`define OFF_IRQ_STAT  12'h0f0
`define OFF_IRQ_MASK  12'h0f4
`define POS_MASK      31
`define POS_PEND      30
`define POS_DONE      0
`define QBASE_LSB     12
`define QOFF_LSB      4
`define QOFF_MSB      18
`define MA_LSB        2
`define RST_EV_MASK   1'b1
`define RST_IRQ_MASK  3'h7
`define EV_RAISE      0
`define EV_SENT       1
`define EV_DROP       2
`endif

// >>> hw/inval_queue_pkg.sv
package inval_queue_pkg;
    typedef enum logic [3:0] {
        SEL_NONE  = 4'b0000,
        SEL_QHEAD = 4'b0001,
        SEL_QTAIL = 4'b0010,
        SEL_QBLO  = 4'b0011,
        SEL_QBHI  = 4'b0100,
        SEL_DONE  = 4'b0101,
        SEL_CTL   = 4'b0110,
        SEL_DATA  = 4'b0111,
        SEL_ADDR  = 4'b1000,
        SEL_ISTAT = 4'b1001,
        SEL_IMASK = 4'b1010
    } reg_sel_t;
    typedef enum logic {
        MSG_IDLE = 1'b0,
        MSG_HELD = 1'b1
    } msg_state_t;
    typedef struct packed {
        logic [51:0] base_r;
        logic [2:0]  size_r;
        logic [14:0] tail_r;
        logic [14:0] fetch_r;
        logic        done_r;
        logic        mask_r;
        logic [15:0] data_r;
        logic [29:0] addr_r;
        logic [31:0] prdata_r;
        logic        slverr_r;
    } regs_state_t;
    typedef struct packed {
        msg_state_t state_r;
    } sender_state_t;
    typedef struct packed {
        logic [2:0] status_r;
        logic [2:0] mask_r;
        logic       irq_r;
    } irq_state_t;
endpackage : inval_queue_pkg

// >>> hw/event_msg_sender.sv
`timescale 1ns/100ps
`default_nettype none
module event_msg_sender
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // condition inputs
    input  wire logic mask,
    input  wire logic hold,
    input  wire logic raise,
    input  wire logic cancel,
    // message handshake
    output logic      msg_valid,
    input  wire logic msg_ready,
    // status
    output logic      pending,
    output logic      sent,
    output logic      dropped
);
    import inval_queue_pkg::*;
    sender_state_t s_r;
    sender_state_t s_nxt;

    // offer only while unmasked and no transient hold
    always_comb
    begin
        pending   = (s_r.state_r == MSG_HELD);
        msg_valid = pending && !mask && !hold;
        sent      = msg_valid && msg_ready;
        dropped   = pending && cancel && !sent;
        s_nxt     = s_r;
        case (s_r.state_r)
            MSG_IDLE: if (raise) s_nxt.state_r = MSG_HELD;
            MSG_HELD: if (sent || cancel) s_nxt.state_r = MSG_IDLE;
            default:  s_nxt.state_r = MSG_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst) s_r <= '0;
        else     s_r <= s_nxt;
    end

    property p_held_stays;
        @(posedge sys_clk) disable iff (rst)
        pending && (mask || hold) && !cancel |=> pending;
    endproperty
    a_held_stays: assert property (p_held_stays) else $error("pending lost while held");
    property p_sent_clears;
        @(posedge sys_clk) disable iff (rst)
        msg_valid && msg_ready |=> !pending;
    endproperty
    a_sent_clears: assert property (p_sent_clears) else $error("pending after send");
endmodule : event_msg_sender
`default_nettype wire

// >>> hw/sticky_irq_unit.sv
`timescale 1ns/100ps
`default_nettype none
`include "inval_queue_defs.svh"
module sticky_irq_unit
(
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // events and software access
    input  wire logic [2:0] ev,
    input  wire logic [2:0] clr_bits,
    input  wire logic       mask_wr,
    input  wire logic [2:0] mask_wdata,
    // state
    output logic [2:0]      status,
    output logic [2:0]      mask,
    output logic            irq
);
    import inval_queue_pkg::*;
    irq_state_t s_r;
    irq_state_t s_nxt;

    // a new event wins over the read clear of the same bit
    always_comb
    begin
        s_nxt          = s_r;
        s_nxt.status_r = (s_r.status_r & ~clr_bits) | ev;
        if (mask_wr) s_nxt.mask_r = mask_wdata;
        s_nxt.irq_r    = |(s_nxt.status_r & ~s_nxt.mask_r);
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            s_r        <= '0;
            s_r.mask_r <= `RST_IRQ_MASK;
        end
        else s_r <= s_nxt;
    end

    assign status = s_r.status_r;
    assign mask   = s_r.mask_r;
    assign irq    = s_r.irq_r;
endmodule : sticky_irq_unit
`default_nettype wire

// >>> hw/invalidation_queue_event_regs.sv
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "inval_queue_defs.svh"
module invalidation_queue_event_regs
#(
    parameter int HOST_ADDR_WIDTH = 64
)
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // apb slave
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // unit configuration
    input  wire logic        queued_invalidation_support,
    input  wire logic        queue_enabled,
    // descriptor engine side
    input  wire logic        wait_done_notify,
    input  wire logic        fetch_advance,
    input  wire logic        msg_hold,
    output logic [51:0]      queue_base_address,
    output logic [2:0]       queue_size_exponent,
    output logic [14:0]      queue_fetch_offset,
    output logic [14:0]      queue_write_offset,
    // interrupt message
    output logic             msg_valid,
    input  wire logic        msg_ready,
    output logic [15:0]      event_message_payload,
    output logic [31:0]      event_message_target,
    // interrupt
    output logic             irq
);
    import inval_queue_pkg::*;

    regs_state_t s_r;
    regs_state_t s_nxt;
    reg_sel_t    sel;
    logic        sup;
    logic        setup;
    logic        wr_en;
    logic        rd_en;
    logic        raise;
    logic        cancel;
    logic        pending;
    logic        sent;
    logic        dropped;
    logic [2:0]  irq_status;
    logic [2:0]  irq_mask;
    logic [2:0]  irq_clr;
    logic [51:0] base_keep;

    // address decode, shared by read mux and write path
    function automatic reg_sel_t decode(input logic [11:0] a);
        reg_sel_t r;
        r = SEL_NONE;
        if (a == `OFF_QHEAD) r = SEL_QHEAD;
        else if (a == `OFF_QTAIL) r = SEL_QTAIL;
        else if (a == `OFF_QBASE_LO) r = SEL_QBLO;
        else if (a == `OFF_QBASE_HI) r = SEL_QBHI;
        else if (a == `OFF_DONE) r = SEL_DONE;
        else if (a == `OFF_EV_CTL) r = SEL_CTL;
        else if (a == `OFF_EV_DATA) r = SEL_DATA;
        else if (a == `OFF_EV_ADDR) r = SEL_ADDR;
        else if (a == `OFF_IRQ_STAT) r = SEL_ISTAT;
        else if (a == `OFF_IRQ_MASK) r = SEL_IMASK;
        return r;
    endfunction : decode

    // last entry index of a queue of 2^(x+8) entries
    function automatic logic [14:0] entry_mask(input logic [2:0] x);
        logic [15:0] span;
        span = 16'h1 << ({1'b0, x} + 4'h8);
        return 15'(span - 16'h1);
    endfunction : entry_mask

    // bits at or above the host width are not kept
    function automatic logic [51:0] base_bits();
        logic [63:0] m;
        m = (HOST_ADDR_WIDTH >= 64) ? ~64'h0 : ((64'h1 << HOST_ADDR_WIDTH) - 64'h1);
        return m[63:`QBASE_LSB];
    endfunction : base_bits

    assign base_keep = base_bits();

    // bus phases; without queue support writes fall away
    always_comb
    begin
        sup   = queued_invalidation_support;
        sel   = decode(paddr);
        setup = psel && !penable;
        wr_en = psel && penable && pwrite && sup;
        rd_en = psel && penable && !pwrite;
    end

    // a new condition only when the flag was still clear
    always_comb
    begin
        raise  = sup && wait_done_notify && !s_r.done_r;
        cancel = s_r.done_r && !s_nxt.done_r;
    end

    // only bits captured into the read word are cleared, so a
    // late event between setup and access is never lost
    assign irq_clr = (rd_en && sup && sel == SEL_ISTAT) ? s_r.prdata_r[2:0] : 3'h0;

    // register updates
    always_comb
    begin
        s_nxt = s_r;
        if (wr_en)
        begin
            if (sel == SEL_QTAIL)
            begin
                s_nxt.tail_r = pwdata[`QOFF_MSB:`QOFF_LSB];
            end
            else if (sel == SEL_QBLO)
            begin
                s_nxt.base_r[19:0] = pwdata[31:`QBASE_LSB] & base_keep[19:0];
                s_nxt.size_r       = pwdata[2:0];
            end
            else if (sel == SEL_QBHI)
            begin
                s_nxt.base_r[51:20] = pwdata & base_keep[51:20];
            end
            else if (sel == SEL_DONE)
            begin
                if (pwdata[`POS_DONE]) s_nxt.done_r = 1'b0;
            end
            else if (sel == SEL_CTL)
            begin
                // pending and low reserved bits are not stored
                s_nxt.mask_r = pwdata[`POS_MASK];
            end
            else if (sel == SEL_DATA)
            begin
                s_nxt.data_r = pwdata[15:0];
            end
            else if (sel == SEL_ADDR)
            begin
                s_nxt.addr_r = pwdata[31:`MA_LSB];
            end
        end
        // hardware set wins over a same-cycle software clear
        if (sup && wait_done_notify) s_nxt.done_r = 1'b1;
        // fetch offset walks the ring, zero when disabled
        if (!queue_enabled)
        begin
            s_nxt.fetch_r = 15'h0;
        end
        else if (fetch_advance)
        begin
            s_nxt.fetch_r = (s_r.fetch_r + 15'h1) & entry_mask(s_r.size_r);
        end
        // read word is taken in setup so prdata is a flop
        if (setup)
        begin
            s_nxt.slverr_r = (sel == SEL_NONE);
            s_nxt.prdata_r = 32'h0;
            if (sup)
            begin
                case (sel)
                    SEL_QHEAD: s_nxt.prdata_r[`QOFF_MSB:`QOFF_LSB] = s_r.fetch_r;
                    SEL_QTAIL: s_nxt.prdata_r[`QOFF_MSB:`QOFF_LSB] = s_r.tail_r;
                    SEL_QBLO:  s_nxt.prdata_r = {s_r.base_r[19:0], 9'h0, s_r.size_r};
                    SEL_QBHI:  s_nxt.prdata_r = s_r.base_r[51:20];
                    SEL_DONE:  s_nxt.prdata_r[`POS_DONE] = s_r.done_r;
                    SEL_CTL:   s_nxt.prdata_r = {s_r.mask_r, pending, 30'h0};
                    SEL_DATA:  s_nxt.prdata_r[15:0] = s_r.data_r;
                    SEL_ADDR:  s_nxt.prdata_r = {s_r.addr_r, 2'h0};
                    SEL_ISTAT: s_nxt.prdata_r[2:0] = irq_status;
                    SEL_IMASK: s_nxt.prdata_r[2:0] = irq_mask;
                    default:   s_nxt.prdata_r = 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            s_r        <= '0;
            s_r.mask_r <= `RST_EV_MASK;
        end
        else s_r <= s_nxt;
    end

    // message timing and pending bit
    event_msg_sender u_sender
    (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .mask      (s_r.mask_r),
        .hold      (msg_hold),
        .raise     (raise),
        .cancel    (cancel),
        .msg_valid (msg_valid),
        .msg_ready (msg_ready),
        .pending   (pending),
        .sent      (sent),
        .dropped   (dropped)
    );

    // local status interrupt on block events
    sticky_irq_unit u_irq
    (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .ev         ({dropped, sent, raise}),
        .clr_bits   (irq_clr),
        .mask_wr    (wr_en && sel == SEL_IMASK),
        .mask_wdata (pwdata[2:0]),
        .status     (irq_status),
        .mask       (irq_mask),
        .irq        (irq)
    );

    // zero-wait slave; error only on unmapped offsets
    assign pready                = 1'b1;
    assign prdata                = s_r.prdata_r;
    assign pslverr               = s_r.slverr_r && psel && penable;
    assign queue_base_address    = s_r.base_r;
    assign queue_size_exponent   = s_r.size_r;
    assign queue_fetch_offset    = s_r.fetch_r;
    assign queue_write_offset    = s_r.tail_r;
    assign event_message_payload = s_r.data_r;
    assign event_message_target  = {s_r.addr_r, 2'h0};

    // checks on the block's own outputs and state
    sequence s_ctl_write;
        psel && penable && pwrite && sup && sel == SEL_CTL;
    endsequence

    sequence s_new_cond;
        sup && wait_done_notify && !s_r.done_r;
    endsequence

    property p_mask_reset;
        @(posedge sys_clk) disable iff (rst)
        $past(rst) |-> s_r.mask_r;
    endproperty
    a_mask_reset: assert property (p_mask_reset) else $error("mask not set after reset");

    property p_no_send_masked;
        @(posedge sys_clk) disable iff (rst)
        s_r.mask_r |-> !msg_valid;
    endproperty
    a_no_send_masked: assert property (p_no_send_masked) else $error("message while masked");

    property p_send_unmasked;
        @(posedge sys_clk) disable iff (rst)
        s_new_cond ##1 (!s_r.mask_r && !msg_hold && s_r.done_r) |-> msg_valid;
    endproperty
    a_send_unmasked: assert property (p_send_unmasked) else $error("unmasked message not sent");

    property p_pending_set;
        @(posedge sys_clk) disable iff (rst)
        s_new_cond |=> pending && s_r.done_r;
    endproperty
    a_pending_set: assert property (p_pending_set) else $error("pending not set");

    property p_no_repeat;
        @(posedge sys_clk) disable iff (rst)
        s_r.done_r && wait_done_notify && !pending |=> !pending;
    endproperty
    a_no_repeat: assert property (p_no_repeat) else $error("repeat condition raised");

    property p_clear_drops;
        @(posedge sys_clk) disable iff (rst)
        $fell(s_r.done_r) |-> !pending && !msg_valid;
    endproperty
    a_clear_drops: assert property (p_clear_drops) else $error("held message survived clear");

    property p_fetch_zero;
        @(posedge sys_clk) disable iff (rst)
        !queue_enabled |=> queue_fetch_offset == 15'h0;
    endproperty
    a_fetch_zero: assert property (p_fetch_zero) else $error("fetch offset not reset");

    property p_fetch_wrap;
        @(posedge sys_clk) disable iff (rst)
        queue_enabled && fetch_advance && s_r.fetch_r == entry_mask(s_r.size_r)
        |=> queue_fetch_offset == 15'h0;
    endproperty
    a_fetch_wrap: assert property (p_fetch_wrap) else $error("fetch offset did not wrap");

    property p_done_set;
        @(posedge sys_clk) disable iff (rst)
        sup && wait_done_notify |=> s_r.done_r;
    endproperty
    a_done_set: assert property (p_done_set) else $error("completion flag not set");

    property p_unsup_zero;
        @(posedge sys_clk) disable iff (rst)
        (setup && !sup) ##1 (rd_en && !sup) |-> prdata == 32'h0;
    endproperty
    a_unsup_zero: assert property (p_unsup_zero) else $error("unsupported read not zero");

    property p_pend_readonly;
        @(posedge sys_clk) disable iff (rst)
        s_ctl_write ##0 (pwdata[`POS_MASK] && s_r.mask_r && pending) |=> pending;
    endproperty
    a_pend_readonly: assert property (p_pend_readonly) else $error("pending changed by write");

    // payload must follow the last data write, not only mirror the flop
    property p_payload;
        @(posedge sys_clk) disable iff (rst)
        wr_en && sel == SEL_DATA |=> event_message_payload == $past(pwdata[15:0])
            && event_message_target[1:0] == 2'h0;
    endproperty
    a_payload: assert property (p_payload) else $error("message payload mismatch");
endmodule : invalidation_queue_event_regs
`default_nettype wire

// >>> verif/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "inval_queue_defs.svh"
module tb_top;
    // bench-driven design inputs
    logic        sys_clk;
    logic        rst;
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic        queued_invalidation_support;
    logic        queue_enabled;
    logic        wait_done_notify;
    logic        fetch_advance;
    logic        msg_hold;
    logic        msg_ready;
    // design outputs
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [51:0] queue_base_address;
    logic [2:0]  queue_size_exponent;
    logic [14:0] queue_fetch_offset;
    logic [14:0] queue_write_offset;
    logic        msg_valid;
    logic [15:0] event_message_payload;
    logic [31:0] event_message_target;
    logic        irq;
    // bookkeeping
    int          fails;
    int          compares;
    logic [31:0] rd;
    logic        err;

    invalidation_queue_event_regs u_invalidation_queue_event_regs
    (
        .sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .queued_invalidation_support(queued_invalidation_support),
        .queue_enabled(queue_enabled), .wait_done_notify(wait_done_notify),
        .fetch_advance(fetch_advance), .msg_hold(msg_hold),
        .queue_base_address(queue_base_address), .queue_size_exponent(queue_size_exponent),
        .queue_fetch_offset(queue_fetch_offset), .queue_write_offset(queue_write_offset),
        .msg_valid(msg_valid), .msg_ready(msg_ready),
        .event_message_payload(event_message_payload),
        .event_message_target(event_message_target), .irq(irq)
    );

    // 10 mhz clock
    always #50 sys_clk = ~sys_clk;

    // compare and count
    task chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // single verdict point for normal end and watchdog
    task report_and_stop;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    // apb transfer; request held until pready is seen at an edge;
    // only the watchdog ends a wait that never completes
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge sys_clk);
        end
        while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(64'(rd), 64'(e));
    endtask : rdchk

    // one-cycle completion pulse, outputs settled on return
    task pulse_done;
        @(posedge sys_clk);
        wait_done_notify <= 1'b1;
        @(posedge sys_clk);
        wait_done_notify <= 1'b0;
        #1;
    endtask : pulse_done

    task t_reset_values;
        rdchk(`OFF_QBASE_LO, 32'h0);
        rdchk(`OFF_DONE, 32'h0);
        rdchk(`OFF_EV_CTL, 32'h8000_0000);
        rdchk(`OFF_IRQ_MASK, 32'h7);
        chk(64'(pready), 64'h1);
        chk(64'(msg_valid), 64'h0);
    endtask : t_reset_values

    // reserved low bits of the base word must drop out
    task t_config_regs;
        apb(1'b1, `OFF_QBASE_LO, 32'hfedc_bfff);
        apb(1'b1, `OFF_QBASE_HI, 32'h1234_5678);
        rdchk(`OFF_QBASE_LO, 32'hfedc_b007);
        rdchk(`OFF_QBASE_HI, 32'h1234_5678);
        chk(64'(queue_base_address), 64'h1_2345_678f_edcb);
        chk(64'(queue_size_exponent), 64'h7);
        apb(1'b1, `OFF_QTAIL, 32'hffff_ffff);
        rdchk(`OFF_QTAIL, 32'h0007_fff0);
        chk(64'(queue_write_offset), 64'h7fff);
        apb(1'b1, `OFF_EV_DATA, 32'hdead_beef);
        apb(1'b1, `OFF_EV_ADDR, 32'h1234_567b);
        rdchk(`OFF_EV_ADDR, 32'h1234_5678);
        chk(64'(event_message_payload), 64'hbeef);
        chk(64'(event_message_target), 64'h1234_5678);
    endtask : t_config_regs

    // size 0 wraps after 256 entries; disable forces zero
    task t_fetch_wrap;
        apb(1'b1, `OFF_QBASE_LO, 32'hfedc_b000);
        repeat (257)
        begin
            @(posedge sys_clk);
            fetch_advance <= 1'b1;
            @(posedge sys_clk);
            fetch_advance <= 1'b0;
        end
        #1;
        chk(64'(queue_fetch_offset), 64'h1);
        rdchk(`OFF_QHEAD, 32'h0000_0010);
        @(posedge sys_clk);
        queue_enabled <= 1'b0;
        @(posedge sys_clk);
        queue_enabled <= 1'b1;
        #1;
        chk(64'(queue_fetch_offset), 64'h0);
    endtask : t_fetch_wrap

    // held by mask, then released by clearing the mask
    task t_masked_event;
        pulse_done();
        chk(64'(msg_valid), 64'h0);
        rdchk(`OFF_DONE, 32'h1);
        apb(1'b1, `OFF_EV_CTL, 32'hffff_ffff);
        rdchk(`OFF_EV_CTL, 32'hc000_0000);
        repeat (3) @(posedge sys_clk);
        #1;
        chk(64'(msg_valid), 64'h0);
        chk(64'(irq), 64'h0);
        apb(1'b1, `OFF_EV_CTL, 32'h0);
        #1;
        chk(64'(msg_valid), 64'h1);
        @(posedge sys_clk);
        msg_ready <= 1'b1;
        @(posedge sys_clk);
        msg_ready <= 1'b0;
        #1;
        chk(64'(msg_valid), 64'h0);
        rdchk(`OFF_EV_CTL, 32'h0);
        apb(1'b1, `OFF_IRQ_MASK, 32'h6);
        @(posedge sys_clk);
        #1;
        chk(64'(irq), 64'h1);
        rdchk(`OFF_IRQ_STAT, 32'h3);
        @(posedge sys_clk);
        #1;
        chk(64'(irq), 64'h0);
    endtask : t_masked_event

    // flag still set: second completion is no new condition
    task t_repeat_event;
        pulse_done();
        chk(64'(msg_valid), 64'h0);
        rdchk(`OFF_EV_CTL, 32'h0);
        rdchk(`OFF_IRQ_STAT, 32'h0);
        // a written one must not raise the read-only pending bit
        apb(1'b1, `OFF_EV_CTL, 32'h4000_0000);
        rdchk(`OFF_EV_CTL, 32'h0);
    endtask : t_repeat_event

    // transient hold, then software clears the flag: message dropped
    task t_drop;
        apb(1'b1, `OFF_DONE, 32'h1);
        rdchk(`OFF_DONE, 32'h0);
        @(posedge sys_clk);
        msg_hold <= 1'b1;
        pulse_done();
        chk(64'(msg_valid), 64'h0);
        rdchk(`OFF_EV_CTL, 32'h4000_0000);
        apb(1'b1, `OFF_DONE, 32'h1);
        rdchk(`OFF_EV_CTL, 32'h0);
        @(posedge sys_clk);
        msg_hold <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        chk(64'(msg_valid), 64'h0);
        rdchk(`OFF_IRQ_STAT, 32'h5);
    endtask : t_drop

    // feature absent: reads zero, writes and events ignored
    task t_unsupported;
        @(posedge sys_clk);
        queued_invalidation_support <= 1'b0;
        rdchk(`OFF_EV_CTL, 32'h0);
        rdchk(`OFF_QBASE_HI, 32'h0);
        apb(1'b1, `OFF_EV_DATA, 32'h1111);
        pulse_done();
        chk(64'(msg_valid), 64'h0);
        @(posedge sys_clk);
        queued_invalidation_support <= 1'b1;
        rdchk(`OFF_EV_DATA, 32'h0000_beef);
        rdchk(`OFF_DONE, 32'h0);
        apb(1'b0, 12'h0b0, 32'h0);
        chk(64'({err, rd}), 64'h1_0000_0000);
        apb(1'b0, `OFF_EV_ADDR, 32'h0);
        chk(64'(err), 64'h0);
    endtask : t_unsupported

    // watchdog, well beyond the expected run of about 670 cycles
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        report_and_stop();
    end

    // reset, then the scenarios in order
    initial
    begin
        sys_clk = 1'b0;
        rst = 1'b1;
        paddr = 12'h0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0;
        queued_invalidation_support = 1'b1;
        queue_enabled = 1'b1;
        wait_done_notify = 1'b0;
        fetch_advance = 1'b0;
        msg_hold = 1'b0;
        msg_ready = 1'b0;
        fails = 0;
        compares = 0;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset_values();
        t_config_regs();
        t_fetch_wrap();
        t_masked_event();
        t_repeat_event();
        t_drop();
        t_unsupported();
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
